// ==== shared/bfs_regs.svh ====
// constants of the boot flash / peripheral spi master
// assumes a 125 MHz core clock and one synchronous domain
// What this block does
// - flash boot default, drives three flash pins: sck, flash select and lane 0
// - send read command, 24-bit zero address
// - strap on lane 1: high selects host
// - first nibble received is low nibble
// - peripheral master only after successful boot
// - peripheral write data comes from tx port
// - peripheral spi clock runs at 1 MHz
// - peripheral write carries at most 128 bytes
// - peripheral read returns at most 56 bytes
// - host boot bytes arrive lsb first
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH
`define BFS_CLK_NS        8
`define BFS_STRAP_HOST    1'b1
`define BFS_START_ADDR    24'h00_0000
`define BFS_CMD_ADDR_BITS 6'h20
`define BFS_PSCK_HALF_NS  500
`define BFS_PSCK_HALF_CYC ((`BFS_PSCK_HALF_NS + `BFS_CLK_NS - 1) / `BFS_CLK_NS)
`define BFS_PWR_MAX       8'h80
`define BFS_PRD_MAX       6'h38
`define BFS_FIFO_DEPTH    32
`define BFS_BYTE_BITS     8
`endif

// ==== shared/bfs_pkg.sv ====
// types shared by the boot flash / peripheral spi master
// assumes bfs_regs.svh for the numeric constants
package bfs_pkg;

	typedef enum logic [3:0] {
		S_STRAP,
		S_FCMD,
		S_FDUMMY,
		S_FREAD,
		S_HOST,
		S_IDLE,
		S_PWR,
		S_PRD,
		S_GAP
	} bfs_state_t;

	// one peripheral transaction: write bytes then read bytes under one select
	typedef struct packed {
		logic [7:0] wlen;
		logic [5:0] rlen;
	} bfs_pcmd_t;

endpackage : bfs_pkg

// ==== rtl/bfs_boot_spi.sv ====
// boot-time flash sequencer, host slave boot and peripheral spi master
// assumes all pin inputs are synchronous to i_clk; pads resolved outside
`include "bfs_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module bfs_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 32,
	localparam int unsigned AW   = $clog2(DEPTH)
) (
	input  wire logic         i_clk,    // core clock
	input  wire logic         i_rst_n,  // async reset
	input  wire logic         i_valid,  // write side valid
	input  wire logic [W-1:0] i_data,   // write data
	output logic              o_ready,  // not full
	output logic              o_valid,  // not empty
	output logic      [W-1:0] o_data,   // head entry
	input  wire logic         i_ready   // read side ready
);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;
	wire          wr = i_valid && o_ready;
	wire          rd = o_valid && i_ready;

	assign o_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign o_valid = wp_q != rp_q;
	assign o_data  = mem_q[rp_q[AW-1:0]];

	for (genvar g = 0; g < DEPTH; g++) begin : g_ent
		always_ff @(posedge i_clk) begin
			if (wr && wp_q[AW-1:0] == AW'(g))
				mem_q[g] <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_q + (AW+1)'(wr);
			rp_q <= rp_q + (AW+1)'(rd);
		end
	end
endmodule : bfs_fifo

////////////////////////////////////////////////////////////////////////////////
module bfs_boot_spi
	import bfs_pkg::*;
#(
	parameter int unsigned BOOT_BYTES = 1024,   // image length fetched at boot
	parameter logic [7:0]  FLASH_CMD  = 8'h6B,  // quad output read opcode
	parameter int unsigned DUMMY_CLKS = 8,      // at least 1
	parameter int unsigned FL_HALF    = 2,      // flash sck half period, cycles
	parameter int unsigned FIFO_DEPTH = `BFS_FIFO_DEPTH
) (
	input  wire logic       i_clk,             // 125 MHz core clock
	input  wire logic       i_rst_n,           // async reset, active low
	input  wire logic [3:0] i_flash_lane,      // lane pads in; [1] is boot strap
	output logic      [3:0] o_flash_lane,      // lane pads out; [0] is mosi
	output logic      [3:0] o_flash_lane_oe_n, // low = drive lane
	output logic            o_sck,             // serial clock, mode 0
	output logic            o_sck_oe_n,        // low = drive sck
	output logic            o_flash_cs_n,      // flash select
	output logic            o_periph_cs_n,     // peripheral select
	input  wire logic       i_host_sck,        // host boot clock
	input  wire logic       i_host_cs_n,       // host boot select
	input  wire logic       i_host_mosi,       // host boot data
	input  bfs_pcmd_t       i_cmd,             // peripheral transaction
	input  wire logic       i_cmd_valid,       // command offered
	output logic            o_cmd_ready,       // command accepted this cycle
	output logic            o_cmd_err,         // pulse: length refused
	input  wire logic [7:0] i_tx_data,         // byte to write
	input  wire logic       i_tx_valid,        // write byte offered
	output logic            o_tx_ready,        // write byte taken
	output logic      [7:0] o_rx_data,         // boot image or read byte
	output logic            o_rx_valid,        // rx byte present
	input  wire logic       i_rx_ready,        // rx byte consumed
	output logic            o_boot_done,       // boot finished
	output logic            o_boot_host,       // host boot selected
	output logic            o_overrun          // sticky: host byte dropped
);
	bfs_state_t  state_q;
	bfs_state_t  state_d;
	logic [6:0]  div_q;
	logic        sck_q;
	logic [5:0]  cnt_q;
	logic [31:0] sh_q;
	logic        nib_q;
	logic [3:0]  lo_q;
	logic [7:0]  rxsh_q;
	logic [15:0] bytes_q;
	logic [7:0]  wleft_q;
	logic [5:0]  rleft_q;
	logic        ld_q;
	logic [7:0]  hsh_q;
	logic [2:0]  hbit_q;
	logic        hsck_q;
	logic        boot_done_q;
	logic        host_q;
	logic        ovr_q;
	logic        err_q;
	logic        cmd_rdy_q;
	logic        tx_rdy_q;
	logic        fcs_n_q;
	logic        pcs_n_q;
	logic        sck_oe_n_q;
	logic [3:0]  oe_n_q;
	logic [7:0]  rx_q;
	logic        rx_v_q;
	logic        fifo_in_rdy;
	logic        fifo_out_v;
	logic [7:0]  fifo_out_d;

	////////////////////////////////////////////////////////////////////////
	wire       flash_ph  = state_q inside {S_FCMD, S_FDUMMY, S_FREAD};
	wire       periph_ph = state_q inside {S_PWR, S_PRD};
	wire [6:0] half      = (flash_ph || (state_q == S_GAP && !boot_done_q)) ?
	                       7'(FL_HALF) : 7'(`BFS_PSCK_HALF_CYC);
	// hold sck low, never mid high phase, while the fifo or tx byte is missing
	wire       stall_rd  = ((state_q == S_FREAD && nib_q) || (state_q == S_PRD && cnt_q == 6'h01))
	                       && !sck_q && !fifo_in_rdy;
	wire       stall_wr  = state_q == S_PWR && !ld_q;
	wire       run       = (flash_ph || periph_ph) && !stall_rd && !stall_wr;
	wire       tick      = run && div_q == half - 7'h01;
	wire       gtick     = state_q == S_GAP && div_q == half - 7'h01;
	wire       rise      = tick && !sck_q;
	wire       fall      = tick && sck_q;
	wire       last_byte = bytes_q == 16'(BOOT_BYTES - 1);
	wire       fl_push   = state_q == S_FREAD && rise && nib_q;
	wire       p_push    = state_q == S_PRD && rise && cnt_q == 6'h01;
	wire       hs_rise   = state_q == S_HOST && i_host_sck && !hsck_q && !i_host_cs_n;
	wire       h_push    = hs_rise && hbit_q == 3'h7;
	wire       push      = fl_push || p_push || h_push;
	wire [7:0] push_data = fl_push ? {i_flash_lane, lo_q} :
	                       p_push  ? {rxsh_q[6:0], i_flash_lane[1]} :
	                                 {i_host_mosi, hsh_q[7:1]};
	wire       cmd_take  = cmd_rdy_q && i_cmd_valid;
	wire       cmd_bad   = i_cmd.wlen > `BFS_PWR_MAX || i_cmd.rlen > `BFS_PRD_MAX
	                       || (i_cmd.wlen == 8'h00 && i_cmd.rlen == 6'h00);
	wire       tx_take   = tx_rdy_q && i_tx_valid;
	wire       rx_load   = fifo_out_v && (!rx_v_q || i_rx_ready);
	wire       step_dn   = fall && state_q inside {S_FCMD, S_FDUMMY, S_PWR};

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_STRAP:  state_d = (i_flash_lane[1] == `BFS_STRAP_HOST) ? S_HOST : S_FCMD;
			S_FCMD:   if (fall && cnt_q == 6'h01) state_d = S_FDUMMY;
			S_FDUMMY: if (fall && cnt_q == 6'h01) state_d = S_FREAD;
			S_FREAD:  if (fl_push && last_byte) state_d = S_GAP;
			S_HOST:   if (h_push && last_byte) state_d = S_IDLE;
			S_IDLE:   if (cmd_take && !cmd_bad) state_d = (i_cmd.wlen != 8'h00) ? S_PWR : S_PRD;
			S_PWR: begin
				if (fall && cnt_q == 6'h01 && wleft_q == 8'h01)
					state_d = (rleft_q != 6'h00) ? S_PRD : S_GAP;
			end
			S_PRD:    if (p_push && rleft_q == 6'h01) state_d = S_GAP;
			S_GAP:    if (gtick && !sck_q) state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= S_STRAP;
			div_q   <= 7'h00;
			sck_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q   <= (tick || gtick || state_d != state_q || !(run || state_q == S_GAP)) ?
			           7'h00 : div_q + 7'h01;
			sck_q   <= sck_q ^ (tick || (gtick && sck_q));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outbound shifter: command+address, dummies, peripheral write bytes
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_q  <= 32'h0000_0000;
			cnt_q <= 6'h00;
			ld_q  <= 1'b0;
		end else if (state_q == S_STRAP && state_d == S_FCMD) begin
			sh_q  <= {FLASH_CMD, `BFS_START_ADDR};
			cnt_q <= `BFS_CMD_ADDR_BITS;
		end else if (state_q == S_FCMD && state_d == S_FDUMMY) begin
			cnt_q <= 6'(DUMMY_CLKS);
		end else if (tx_take) begin
			sh_q  <= {i_tx_data, 24'h00_0000};
			cnt_q <= 6'h08;
			ld_q  <= 1'b1;
		end else if (state_q == S_PWR && state_d == S_PRD || state_q == S_IDLE && state_d == S_PRD) begin
			sh_q  <= 32'h0000_0000;
			cnt_q <= 6'h08;
			ld_q  <= 1'b0;
		end else if (step_dn) begin
			sh_q  <= {sh_q[30:0], 1'b0};
			cnt_q <= cnt_q - 6'h01;
			ld_q  <= ld_q && cnt_q != 6'h01;
		end else if (rise && state_q == S_PRD) begin
			cnt_q <= (cnt_q == 6'h01) ? 6'h08 : cnt_q - 6'h01;
		end
	end

	// inbound assembly and transaction counters
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nib_q   <= 1'b0;
			lo_q    <= 4'h0;
			rxsh_q  <= 8'h00;
			bytes_q <= 16'h0000;
			wleft_q <= 8'h00;
			rleft_q <= 6'h00;
		end else begin
			if (rise && state_q == S_FREAD) begin
				nib_q <= !nib_q;
				if (!nib_q)
					lo_q <= i_flash_lane;
			end
			if (rise && state_q == S_PRD)
				rxsh_q <= {rxsh_q[6:0], i_flash_lane[1]};
			if (fl_push || h_push)
				bytes_q <= bytes_q + 16'h0001;
			if (cmd_take) begin
				wleft_q <= i_cmd.wlen;
				rleft_q <= i_cmd.rlen;
			end else begin
				if (fall && state_q == S_PWR && cnt_q == 6'h01)
					wleft_q <= wleft_q - 8'h01;
				if (p_push)
					rleft_q <= rleft_q - 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host cannot be stalled: a byte arriving with the fifo full is dropped
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hsck_q <= 1'b0;
			hsh_q  <= 8'h00;
			hbit_q <= 3'h0;
			ovr_q  <= 1'b0;
		end else begin
			hsck_q <= i_host_sck;
			if (i_host_cs_n)
				hbit_q <= 3'h0;
			else if (hs_rise) begin
				hsh_q  <= {i_host_mosi, hsh_q[7:1]};
				hbit_q <= hbit_q + 3'h1;
			end
			if (h_push && !fifo_in_rdy)
				ovr_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin enables and selects follow the next state so they lead sck
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_done_q <= 1'b0;
			host_q      <= 1'b0;
			fcs_n_q     <= 1'b1;
			pcs_n_q     <= 1'b1;
			sck_oe_n_q  <= 1'b1;
			oe_n_q      <= 4'hF;
		end else begin
			if (state_d == S_IDLE && state_q != S_IDLE)
				boot_done_q <= 1'b1;
			if (state_q == S_STRAP)
				host_q <= state_d == S_HOST;
			fcs_n_q    <= !(state_d inside {S_FCMD, S_FDUMMY, S_FREAD} ||
			               (state_d == S_GAP && !boot_done_q));
			pcs_n_q    <= !(state_d inside {S_PWR, S_PRD} || (state_d == S_GAP && boot_done_q));
			sck_oe_n_q <= state_d inside {S_STRAP, S_HOST};
			oe_n_q     <= {3'h7, !(state_d inside {S_FCMD, S_PWR, S_PRD})};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_rdy_q <= 1'b0;
			err_q     <= 1'b0;
			tx_rdy_q  <= 1'b0;
			rx_q      <= 8'h00;
			rx_v_q    <= 1'b0;
		end else begin
			cmd_rdy_q <= state_d == S_IDLE && !cmd_take && boot_done_q;
			err_q     <= cmd_take && cmd_bad;
			tx_rdy_q  <= state_q == S_PWR && !ld_q && !tx_take;
			if (rx_load) begin
				rx_q   <= fifo_out_d;
				rx_v_q <= 1'b1;
			end else if (i_rx_ready)
				rx_v_q <= 1'b0;
		end
	end

	bfs_fifo #(
		.W     (`BFS_BYTE_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_valid (push),
		.i_data  (push_data),
		.o_ready (fifo_in_rdy),
		.o_valid (fifo_out_v),
		.o_data  (fifo_out_d),
		.i_ready (!rx_v_q || i_rx_ready)
	);

	assign o_flash_lane      = {3'h0, sh_q[31]};
	assign o_flash_lane_oe_n = oe_n_q;
	assign o_sck             = sck_q;
	assign o_sck_oe_n        = sck_oe_n_q;
	assign o_flash_cs_n      = fcs_n_q;
	assign o_periph_cs_n     = pcs_n_q;
	assign o_cmd_ready       = cmd_rdy_q;
	assign o_cmd_err         = err_q;
	assign o_tx_ready        = tx_rdy_q;
	assign o_rx_data         = rx_q;
	assign o_rx_valid        = rx_v_q;
	assign o_boot_done       = boot_done_q;
	assign o_boot_host       = host_q;
	assign o_overrun         = ovr_q;

	////////////////////////////////////////////////////////////////////////
	logic [6:0] high_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			high_q <= 7'h00;
		else
			high_q <= sck_q ? high_q + 7'h01 : 7'h00;
	end

	AST_STRAP_SEL: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		state_q == S_STRAP |=> (state_q == S_HOST) == $past(i_flash_lane[1]) ##1 o_boot_host == (state_q == S_HOST)
	) else $error("boot strap selected wrong path");
	AST_FLASH_PINS: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(state_q == S_FCMD) |-> !o_sck_oe_n && !o_flash_lane_oe_n[0] && !o_flash_cs_n
	) else $error("flash pins not driven at boot");
	AST_ZERO_ADDR: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(state_q == S_FCMD) |-> sh_q == {FLASH_CMD, `BFS_START_ADDR} && cnt_q == `BFS_CMD_ADDR_BITS
	) else $error("read command or start address wrong");
	AST_LOW_NIBBLE: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		rise && state_q == S_FREAD && !nib_q |=> lo_q == $past(i_flash_lane)
	) else $error("first nibble not placed low");
	AST_AFTER_BOOT: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		periph_ph || o_cmd_ready |-> boot_done_q && o_flash_cs_n
	) else $error("peripheral master used before boot");
	AST_PSCK_HIGH: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		$fell(sck_q) && !o_periph_cs_n |-> high_q == 7'(`BFS_PSCK_HALF_CYC)
	) else $error("peripheral sck high phase wrong");
	AST_WR_LIMIT: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		state_q == S_PWR |-> wleft_q <= `BFS_PWR_MAX && wleft_q != 8'h00
	) else $error("write length over limit");
	AST_RD_LIMIT: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		cmd_take && i_cmd.rlen > `BFS_PRD_MAX |=> o_cmd_err && state_q == S_IDLE
	) else $error("oversize read not refused");
	AST_HOST_LSB: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		h_push |-> push_data[6:0] == hsh_q[7:1]
	) else $error("host byte not lsb first");
	AST_CS_HELD: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		periph_ph && sck_q |-> !o_periph_cs_n ##1 !o_periph_cs_n
	) else $error("select dropped inside transaction");
endmodule : bfs_boot_spi

// ==== verification/bfs_flash_model.sv ====
// stand-in for the boot flash and one spi peripheral on the lane pins
// assumes a mode 0 clock from the device and one select for each part
module bfs_flash_model #(
	parameter int unsigned DUMMY = 1
) (
	input  wire logic        i_sck,   // serial clock from device
	input  wire logic        i_fcs_n, // flash select
	input  wire logic        i_pcs_n, // peripheral select
	input  wire logic        i_mosi,  // lane 0 from device
	output logic      [3:0]  o_lane,  // lanes toward device
	output logic             o_drv,   // lane 1 driven by us
	output logic      [31:0] o_cmd,   // command and address seen
	output logic      [7:0]  o_wbyte  // first peripheral byte seen
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned rises = 0;
	int unsigned nib;
	logic [7:0]  b;
	initial begin
		o_lane  = 4'h0;
		o_drv   = 1'b0;
		o_cmd   = 32'h0000_0000;
		o_wbyte = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////////
	always @(negedge i_fcs_n or negedge i_pcs_n) begin
		rises = 0;
		if (!i_pcs_n) begin
			o_lane[1] = 1'b1;
			o_drv     = 1'b1;
		end
	end
	// released lanes show the inverse, never a stale level
	always @(posedge i_fcs_n or posedge i_pcs_n) begin
		o_drv  = 1'b0;
		o_lane = ~o_lane;
	end
	always @(posedge i_sck) begin
		rises++;
		if (!i_fcs_n && rises <= 32)
			o_cmd = {o_cmd[30:0], i_mosi};
		if (!i_pcs_n && rises <= 8)
			o_wbyte = {o_wbyte[6:0], i_mosi};
	end
	// image stored low nibble first, quad read enabled
	always @(negedge i_sck) begin
		if (!i_fcs_n && rises >= 32 + DUMMY) begin
			nib    = rises - 32 - DUMMY;
			b      = 8'h30 + nib[8:1];
			o_lane = nib[0] ? b[7:4] : b[3:0];
			o_drv  = 1'b1;
		end
		if (!i_pcs_n) begin
			b         = 8'hc0 + rises[10:3];
			o_lane[1] = b[~rises[2:0]];
		end
	end
endmodule : bfs_flash_model

// ==== verification/bfs_boot_spi_tb.sv ====
// self-checking bench: host boot, flash boot with stall, peripheral use
// assumes the flash model above on the lane pins
module bfs_boot_spi_tb
	import bfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned NB = 40;
	logic       clk = 1'b0, rst_n = 1'b0, strap = 1'b0;
	logic       hsck = 1'b0, hcs_n = 1'b1, hmosi = 1'b0;
	bfs_pcmd_t  cmd = '0;
	logic       cmd_valid = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1;
	logic [7:0] tx_data = 8'h00;
	logic [3:0] lane_o, oe_n, m_lane, lane_in;
	logic       sck, sck_oe_n, fcs_n, pcs_n, cmd_ready, cmd_err, tx_ready;
	logic [7:0] rx_data, m_wbyte;
	logic       rx_valid, boot_done, boot_host, overrun, m_drv;
	logic [31:0] m_cmd;
	logic [7:0] rxq[$];
	int         errors = 0, comparisons = 0, cyc = 0;
	always #4 clk = ~clk;
	// pad resolution: strap stands on lane 1 while the flash is silent
	assign lane_in = {m_lane[3:2], m_drv ? m_lane[1] : strap, !oe_n[0] ? lane_o[0] : m_lane[0]};
	bfs_boot_spi #(.BOOT_BYTES(NB), .FLASH_CMD(8'h6B), .DUMMY_CLKS(1)) i_bfs_boot_spi (
		.i_clk(clk), .i_rst_n(rst_n), .i_flash_lane(lane_in), .o_flash_lane(lane_o),
		.o_flash_lane_oe_n(oe_n), .o_sck(sck), .o_sck_oe_n(sck_oe_n), .o_flash_cs_n(fcs_n),
		.o_periph_cs_n(pcs_n), .i_host_sck(hsck), .i_host_cs_n(hcs_n), .i_host_mosi(hmosi),
		.i_cmd(cmd), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .o_cmd_err(cmd_err),
		.i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
		.o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_boot_done(boot_done),
		.o_boot_host(boot_host), .o_overrun(overrun));
	bfs_flash_model #(.DUMMY(1)) i_bfs_flash_model (
		.i_sck(sck), .i_fcs_n(fcs_n), .i_pcs_n(pcs_n), .i_mosi(lane_o[0]),
		.o_lane(m_lane), .o_drv(m_drv), .o_cmd(m_cmd), .o_wbyte(m_wbyte));
	always @(posedge clk)
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back(rx_data);
	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rx(input logic [7:0] first);
		for (int i = 0; i < rxq.size(); i++)
			chk(rxq[i], first + i[7:0]);
	endtask : chk_rx
	task automatic do_reset(input logic s);
		@(posedge clk);
		rst_n     <= 1'b0;
		strap     <= s;
		rx_ready  <= 1'b1;
		cmd_valid <= 1'b0;
		tx_valid  <= 1'b0;
		repeat (16) @(posedge clk);
		#1;
		chk({fcs_n, pcs_n, sck_oe_n}, 3'b111);
		chk({cmd_ready, boot_done}, 2'b00);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rxq.delete();
	endtask : do_reset
	task automatic send_cmd(input logic [7:0] w, input logic [5:0] r);
		@(posedge clk);
		cmd       <= '{wlen: w, rlen: r};
		cmd_valid <= 1'b1;
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
	endtask : send_cmd
	////////////////////////////////////////////////////////////////////////////
	task automatic sc_host;
		logic [7:0] b;
		do_reset(1'b1);
		chk({boot_host, sck_oe_n}, 2'b11);
		hcs_n <= 1'b0;
		for (int i = 0; i < NB; i++) begin
			b = 8'h90 + i[7:0];
			for (int k = 0; k < 8; k++) begin
				hmosi <= b[k];
				repeat (2) @(posedge clk);
				hsck <= 1'b1;
				repeat (2) @(posedge clk);
				hsck <= 1'b0;
			end
		end
		hcs_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk({boot_done, overrun}, 2'b10);
		chk(rxq.size(), NB);
		chk_rx(8'h90);
	endtask : sc_host
	// fifo fills and the flash clock must stall with select held
	task automatic sc_flash;
		do_reset(1'b0);
		rx_ready  <= 1'b0;
		cmd       <= '{wlen: 8'd1, rlen: 6'd0};
		cmd_valid <= 1'b1;
		repeat (800) @(posedge clk);
		chk({boot_done, boot_host, cmd_ready, pcs_n}, 4'b0001);
		chk({fcs_n, sck_oe_n, sck, oe_n}, {3'b000, 4'hF});
		chk(m_cmd, {8'h6B, 24'h00_0000});
		cmd_valid <= 1'b0;
		rx_ready  <= 1'b1;
		while (boot_done !== 1'b1) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(fcs_n, 1'b1);
		chk(rxq.size(), NB);
		chk_rx(8'h30);
	endtask : sc_flash
	task automatic sc_periph;
		int   n;
		logic e;
		bfs_pcmd_t bad[3] = '{'{8'd129, 6'd0}, '{8'd0, 6'd57}, '{8'd0, 6'd0}};
		foreach (bad[j]) begin
			send_cmd(bad[j].wlen, bad[j].rlen);
			e = 1'b0;
			repeat (2) begin
				#1 e = e | cmd_err;
				@(posedge clk);
			end
			chk(e, 1'b1);
			chk(pcs_n, 1'b1);
			repeat (3) @(posedge clk);
		end
		rxq.delete();
		tx_data  <= 8'h5A;
		tx_valid <= 1'b1;
		send_cmd(8'd1, 6'd56);
		do @(posedge clk); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
		#1 chk({pcs_n, fcs_n}, 2'b01);
		while (sck !== 1'b1) @(posedge clk);
		n = 0;
		while (sck === 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk(n, 63);
		while (pcs_n !== 1'b1) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(m_wbyte, 8'h5A);
		chk(rxq.size(), 56);
		chk_rx(8'hc1);
	endtask : sc_periph
	////////////////////////////////////////////////////////////////////////////
	initial begin
		sc_host();
		sc_flash();
		sc_periph();
		end_sim();
	end
endmodule : bfs_boot_spi_tb
